// ### common/oalp_pkg.sv
package oalp_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_INSTR  = 12'h004;
  localparam logic [11:0] ADDR_ACC    = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;
  localparam logic [11:0] ADDR_BANK   = 12'h010;
  localparam logic [11:0] ADDR_PTR0   = 12'h014;
  localparam logic [11:0] ADDR_PTR1   = 12'h018;
  localparam logic [11:0] ADDR_PTR2   = 12'h01c;
  localparam logic [11:0] ADDR_FILE   = 12'h400;
  localparam logic [11:0] FILE_MASK   = 12'hc00;

  // ----------------------------------------------------------------------
  // Opcode fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_OR_LIT   = 8'h09;
  localparam logic [5:0] OP_OR_FILE  = 6'h04;
  localparam logic [9:0] OP_PTR_HI   = 10'h3b8;
  localparam logic [7:0] OP_PTR_LO   = 8'hf0;
  localparam int         D_BIT       = 9;
  localparam int         A_BIT       = 8;
  localparam logic [7:0] INDEX_LIMIT = 8'h5f;
  localparam logic [1:0] PTR_COUNT   = 2'h3;

  // ----------------------------------------------------------------------
  // Status and control fields
  // ----------------------------------------------------------------------
  localparam int N_BIT   = 1;
  localparam int Z_BIT   = 0;
  localparam int EXT_BIT = 0;

  typedef enum logic [1:0] {
    OALP_Q1,
    OALP_Q2,
    OALP_Q3,
    OALP_Q4
  } oalp_phase_e;

endpackage

// ### hw/oalp_decode.sv
`timescale 1ns/1ps
module oalp_decode (
  // Instruction word
  input  wire logic [15:0] instr,
  input  wire logic        second_word,
  // Decoded class
  output logic             is_or_lit,
  output logic             is_or_file,
  output logic             is_ptr_hi,
  output logic             is_ptr_lo
);
  import oalp_pkg::*;

  assign is_or_lit  = !second_word && (instr[15:8] == OP_OR_LIT);
  assign is_or_file = !second_word && (instr[15:10] == OP_OR_FILE);
  assign is_ptr_hi  = !second_word && (instr[15:6] == OP_PTR_HI)
                      && (instr[5:4] != PTR_COUNT);
  assign is_ptr_lo  = second_word && (instr[15:8] == OP_PTR_LO);

endmodule

// ### hw/oalp_alu.sv
`timescale 1ns/1ps
module oalp_alu (
  // Operands
  input  wire logic [7:0] acc,
  input  wire logic [7:0] operand,
  // Result and flags
  output logic      [7:0] result,
  output logic            neg,
  output logic            zero
);
  assign result = acc | operand;
  assign neg    = result[7];
  assign zero   = (result == 8'h00);
endmodule

// ### hw/oalp_core.sv
`timescale 1ns/1ps
module oalp_core #(
  parameter int FILE_DEPTH = 256
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  // AHB-Lite slave
  input  wire logic                       hsel,
  input  wire logic [11:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  // Execution status
  output logic                            busy_ff
);
  import oalp_pkg::*;

  // The file RAM is indexed by one address byte, so only this depth is served.
  if (FILE_DEPTH != 256) begin : g_depth_check
    $error("oalp_core: FILE_DEPTH must be 256");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0]  file_mem [FILE_DEPTH];
  logic [7:0]  acc_ff;
  logic        neg_ff;
  logic        zero_ff;
  logic [3:0]  bank_ff;
  logic        ext_ff;
  logic [11:0] ptr_ff [3];
  logic [15:0] instr_ff;
  logic        pend_ff;
  logic        second_ff;
  logic [1:0]  sel_ff;
  oalp_phase_e phase_ff;
  logic [7:0]  opnd_ff;
  logic [7:0]  res_ff;
  logic        rn_ff;
  logic        rz_ff;
  logic [11:0] addr_ff;
  logic        write_ff;
  logic [31:0] rdata_ff;
  logic        ready_ff;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic        is_or_lit;
  logic        is_or_file;
  logic        is_ptr_hi;
  logic        is_ptr_lo;

  oalp_decode u_decode (
    .instr       (instr_ff),
    .second_word (second_ff),
    .is_or_lit   (is_or_lit),
    .is_or_file  (is_or_file),
    .is_ptr_hi   (is_ptr_hi),
    .is_ptr_lo   (is_ptr_lo)
  );

  wire       dest_file = instr_ff[D_BIT];
  wire       bank_sel  = instr_ff[A_BIT];
  wire [7:0] f_addr    = instr_ff[7:0];
  wire [1:0] ptr_idx   = instr_ff[5:4];

  // Effective file address: quick access bank, banked, or indexed off pointer 2.
  wire        indexed  = !bank_sel && ext_ff && (f_addr <= INDEX_LIMIT);
  wire [11:0] idx_addr = ptr_ff[2] + {4'h0, f_addr};
  wire [11:0] eff_addr = indexed  ? idx_addr :
                         bank_sel ? {bank_ff, f_addr} :
                         {(f_addr[7] ? 4'hf : 4'h0), f_addr};
  wire [7:0]  file_rd  = file_mem[eff_addr[7:0]];

  // ----------------------------------------------------------------------
  // ALU
  // ----------------------------------------------------------------------
  logic [7:0] alu_res;
  logic       alu_n;
  logic       alu_z;

  oalp_alu u_alu (
    .acc     (acc_ff),
    .operand (opnd_ff),
    .result  (alu_res),
    .neg     (alu_n),
    .zero    (alu_z)
  );

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire        bus_req   = hsel && hready && htrans[1];
  wire        wr_go     = write_ff;
  wire        wr_ctrl   = wr_go && (addr_ff == ADDR_CTRL);
  wire        wr_instr  = wr_go && (addr_ff == ADDR_INSTR) && !pend_ff;
  wire        wr_acc    = wr_go && (addr_ff == ADDR_ACC) && !pend_ff;
  wire        wr_stat   = wr_go && (addr_ff == ADDR_STATUS) && !pend_ff;
  wire        wr_bank   = wr_go && (addr_ff == ADDR_BANK);
  wire        wr_file   = wr_go && ((addr_ff & FILE_MASK) == ADDR_FILE) && !pend_ff;
  wire        is_ptr_a  = (haddr == ADDR_PTR0) || (haddr == ADDR_PTR1)
                          || (haddr == ADDR_PTR2);
  wire [1:0]  ptr_a_idx = haddr[3:2] - 2'h1;
  wire [31:0] rd_mux    =
      (haddr == ADDR_CTRL)   ? {31'h0, ext_ff} :
      (haddr == ADDR_INSTR)  ? {16'h0, instr_ff} :
      (haddr == ADDR_ACC)    ? {24'h0, acc_ff} :
      (haddr == ADDR_STATUS) ? {29'h0, busy_ff, neg_ff, zero_ff} :
      (haddr == ADDR_BANK)   ? {28'h0, bank_ff} :
      is_ptr_a               ? {20'h0, ptr_ff[ptr_a_idx]} :
      ((haddr & FILE_MASK) == ADDR_FILE) ? {24'h0, file_mem[haddr[9:2]]} :
      32'h0;

  // ----------------------------------------------------------------------
  // Instruction sequencing
  // ----------------------------------------------------------------------
  wire        known    = is_or_lit || is_or_file || is_ptr_hi || is_ptr_lo;
  wire        q4       = pend_ff && (phase_ff == OALP_Q4);
  wire        wr_w     = q4 && (is_or_lit || (is_or_file && !dest_file));
  wire        wr_f     = q4 && is_or_file && dest_file;
  wire        flags_go = q4 && (is_or_lit || is_or_file);
  wire        hi_go    = q4 && is_ptr_hi;
  wire        lo_go    = q4 && is_ptr_lo;
  wire        done     = q4 && !is_ptr_hi;
  wire        start    = wr_instr;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_ff <= OALP_Q1;
      pend_ff  <= 1'b0;
      busy_ff  <= 1'b0;
    end else begin
      if (start || (pend_ff && known)) begin
        phase_ff <= start ? OALP_Q1 : oalp_phase_e'(phase_ff + 2'h1);
      end
      pend_ff <= start ? 1'b1 : (done || (pend_ff && !known && !second_ff)) ? 1'b0
                 : pend_ff;
      busy_ff <= start ? 1'b1 : done ? 1'b0 : busy_ff;
    end
  end

  // Second word of a pointer load: bus writes to the instruction register
  // after the high-byte Q4, while second_ff is set, replace the queued word and must carry the prefix.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      second_ff <= 1'b0;
      sel_ff    <= 2'h0;
      instr_ff  <= 16'h0000;
    end else begin
      if (hi_go) begin
        second_ff <= 1'b1;
        sel_ff    <= ptr_idx;
        instr_ff  <= {OP_PTR_LO, 8'h00};
      end else if (start) begin
        instr_ff <= hwdata[15:0];
      end else if (wr_go && (addr_ff == ADDR_INSTR) && second_ff
                   && (hwdata[15:8] == OP_PTR_LO)) begin
        instr_ff <= hwdata[15:0];
      end else if (lo_go) begin
        second_ff <= 1'b0;
      end
    end
  end

  // Operand capture in Q2 and processing in Q3.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opnd_ff <= 8'h00;
      res_ff  <= 8'h00;
      rn_ff   <= 1'b0;
      rz_ff   <= 1'b0;
      addr_ff <= 12'h000;
    end else begin
      if (pend_ff && phase_ff == OALP_Q2) begin
        opnd_ff <= is_or_file ? file_rd : instr_ff[7:0];
      end
      if (pend_ff && phase_ff == OALP_Q3) begin
        res_ff <= alu_res;
        rn_ff  <= alu_n;
        rz_ff  <= alu_z;
      end
      if (bus_req) begin
        addr_ff <= haddr;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Architectural state written in Q4 or by software
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_ff  <= 8'h00;
      neg_ff  <= 1'b0;
      zero_ff <= 1'b0;
      bank_ff <= 4'h0;
      ext_ff  <= 1'b0;
    end else begin
      acc_ff  <= wr_w ? res_ff : wr_acc ? hwdata[7:0] : acc_ff;
      neg_ff  <= flags_go ? rn_ff : wr_stat ? hwdata[N_BIT] : neg_ff;
      zero_ff <= flags_go ? rz_ff : wr_stat ? hwdata[Z_BIT] : zero_ff;
      bank_ff <= wr_bank ? hwdata[3:0] : bank_ff;
      ext_ff  <= wr_ctrl ? hwdata[EXT_BIT] : ext_ff;
    end
  end

  // Pointers: high nibble on the first word, low byte on the second.
  for (genvar i = 0; i < 3; i++) begin : g_ptr
    wire wr_sw = wr_go && !pend_ff && (addr_ff == ADDR_PTR0 + 12'(4 * i));
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        ptr_ff[i] <= 12'h000;
      end else if (hi_go && ptr_idx == 2'(i)) begin
        ptr_ff[i][11:8] <= instr_ff[3:0];
      end else if (lo_go && sel_ff == 2'(i)) begin
        ptr_ff[i][7:0] <= instr_ff[7:0];
      end else if (wr_sw) begin
        ptr_ff[i] <= hwdata[11:0];
      end
    end
  end

  // File memory has no reset; it is a plain RAM.
  always_ff @(posedge clk) begin
    if (wr_f) begin
      file_mem[eff_addr[7:0]] <= res_ff;
    end else if (wr_file) begin
      file_mem[addr_ff[9:2]] <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Bus response: zero wait states, always OKAY
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      write_ff <= 1'b0;
      rdata_ff <= 32'h0;
      ready_ff <= 1'b1;
    end else begin
      write_ff <= bus_req && hwrite;
      rdata_ff <= (bus_req && !hwrite) ? rd_mux : rdata_ff;
      ready_ff <= 1'b1;
    end
  end

  assign hrdata    = rdata_ff;
  assign hreadyout = ready_ff;
  assign hresp     = 1'b0;

endmodule

// ### testbench/oalp_core_checker.sv
`timescale 1ns/1ps
module oalp_core_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // Bus and status
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        busy_ff
);
  import oalp_pkg::*;
  logic        wr_ff;
  logic [11:0] adr_ff;
  wire         req    = hsel & hready & htrans[1];
  wire         rd_req = req & ~hwrite;
  wire         ins_dp = wr_ff & (adr_ff == ADDR_INSTR);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ff  <= 1'b0;
      adr_ff <= 12'h000;
    end else begin
      wr_ff  <= req & hwrite;
      adr_ff <= haddr;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("ready dropped");
  property p_resp; !hresp; endproperty
  a_resp: assert property (p_resp) else $error("error response");
  property p_lit_len;
    ins_dp && !$past(busy_ff) && hwdata[15:8] == OP_OR_LIT |=> busy_ff[*4] ##1 !busy_ff;
  endproperty
  a_lit_len: assert property (p_lit_len) else $error("literal or length");
  property p_file_len;
    ins_dp && !$past(busy_ff) && hwdata[15:10] == OP_OR_FILE |=> busy_ff[*4] ##1 !busy_ff;
  endproperty
  a_file_len: assert property (p_file_len) else $error("file or length");
  property p_ptr_len;
    ins_dp && !$past(busy_ff) && hwdata[15:6] == OP_PTR_HI && hwdata[5:4] != 2'h3
      |=> busy_ff[*8];
  endproperty
  a_ptr_len: assert property (p_ptr_len) else $error("pointer load ended early");
  property p_unmapped; rd_req && haddr > ADDR_PTR2 && haddr < ADDR_FILE |=> hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_status; rd_req && haddr == ADDR_STATUS |=> hrdata[2] == $past(busy_ff); endproperty
  a_status: assert property (p_status) else $error("status busy mismatch");
  property p_hold; !rd_req |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data changed");
endmodule

// ### testbench/or_and_pointer_load_exec_bench.sv
`timescale 1ns/1ps
module or_and_pointer_load_exec_bench;
  import oalp_pkg::*;
  logic        clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rv, st;
  logic        hready, hreadyout, hresp, busy_ff;
  logic [7:0]  ta [4] = '{8'h9a, 8'h00, 8'h01, 8'h80};
  logic [7:0]  tk [4] = '{8'h35, 8'h00, 8'h7e, 8'h00};
  logic [11:0] pk [3] = '{12'h3ab, 12'hfff, 12'h5c0};
  int          bad_count = 0, check_count = 0;
  assign hready = hreadyout;
  always #2 clk = ~clk;
  oalp_core dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .busy_ff(busy_ff));
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One single transfer; entered right after a rising edge.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0; hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r & m, exp);
  endtask
  task automatic settle;
    int n;
    for (n = 0; n < 40; n++) begin
      bus(1'b0, ADDR_STATUS, 32'h0, st);
      if (st[2] === 1'b0) break;
    end
    chk({31'h0, st[2]}, 32'h0);
  endtask
  function automatic logic [11:0] fa(input logic [7:0] f);
    return ADDR_FILE | {2'b00, f, 2'b00};
  endfunction
  // Register OR: fx is the RAM byte that the operand really lives in.
  task automatic orf(input logic d, input logic a, input logic [7:0] f, input logic [7:0] fx,
                     input logic [7:0] av, input logic [7:0] fv);
    logic [7:0] res;
    res = av | fv;
    wr(ADDR_ACC, {24'h0, av});
    wr(fa(fx), {24'h0, fv});
    wr(ADDR_INSTR, {16'h0, OP_OR_FILE, d, a, f});
    settle;
    rdc(ADDR_ACC, {24'h0, d ? av : res}, 32'hff);
    rdc(fa(fx), {24'h0, d ? res : fv}, 32'hff);
    rdc(ADDR_STATUS, {30'h0, res[7], res == 8'h00}, 32'h3);
  endtask
  initial begin
    #40000;
    bad_count++;
    $display("[FAIL] t=%0t watchdog=%h exp=%h", $time, 1'b1, 1'b0);
    close_out;
  end
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rdc(12'h020, 32'h0, 32'hffffffff);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_ACC, {24'h0, ta[i]});
      wr(ADDR_INSTR, {16'h0, OP_OR_LIT, tk[i]});
      settle;
      rdc(ADDR_ACC, {24'h0, ta[i] | tk[i]}, 32'hff);
      rdc(ADDR_STATUS, {30'h0, ta[i][7] | tk[i][7], (ta[i] | tk[i]) == 8'h00}, 32'h3);
    end
    wr(ADDR_BANK, 32'h2);
    orf(1'b0, 1'b1, 8'h13, 8'h13, 8'h91, 8'h13);
    orf(1'b1, 1'b0, 8'h40, 8'h40, 8'h91, 8'h0c);
    orf(1'b1, 1'b0, 8'h85, 8'h85, 8'h00, 8'h00);
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_PTR2, 32'h010);
    orf(1'b1, 1'b0, 8'h05, 8'h15, 8'h21, 8'h84);
    orf(1'b1, 1'b0, 8'h60, 8'h60, 8'h02, 8'h40);
    orf(1'b1, 1'b1, 8'h05, 8'h05, 8'h08, 8'h01);
    wr(ADDR_CTRL, 32'h0);
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, ADDR_STATUS, 32'h0, rv);
      wr(ADDR_INSTR, {16'h0, OP_PTR_HI, i[1:0], pk[i][11:8]});
      repeat (4) @(posedge clk);
      wr(ADDR_INSTR, {16'h0, OP_PTR_LO, pk[i][7:0]});
      settle;
      rdc(ADDR_PTR0 + 12'(4 * i), {20'h0, pk[i]}, 32'hfff);
      rdc(ADDR_STATUS, {30'h0, rv[1:0]}, 32'h3);
    end
    wr(ADDR_INSTR, {16'h0, OP_PTR_HI, 2'h3, 4'ha});
    rdc(ADDR_PTR2, {20'h0, pk[2]}, 32'hfff);
    rdc(ADDR_PTR0, {20'h0, pk[0]}, 32'hfff);
    wr(ADDR_ACC, 32'h10);
    wr(ADDR_INSTR, {16'h0, OP_OR_LIT, 8'h01});
    @(posedge clk);
    wr(ADDR_ACC, 32'h55);
    settle;
    rdc(ADDR_ACC, 32'h11, 32'hff);
    close_out;
  end
endmodule
bind oalp_core oalp_core_checker u_chk (.clk(clk), .arst_n(arst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .busy_ff(busy_ff));
